// [core/scp_consts.svh]
// constants for the serial mode control port
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define SCP_WORD_BITS 5'h10
`define SCP_MODE_CTRL_IDX 7'h31
`define SCP_MODE_CTRL_RESET 8'hC0
`define SCP_BIT_RESTORE 7
`define SCP_BIT_SYSRST 6
`define SCP_BIT_MODE_HI 5
`define SCP_BIT_MODE_LO 4
`define SCP_BIT_FORMAT 3
`define SCP_BIT_PDOWN 2
`define SCP_BIT_POLARITY 1
`define SCP_BIT_MUTE 0
`endif

// [core/scp_ctrl_port.sv]
// serial mode control port: receives 16-bit words and holds the mode control register
`timescale 1ns/10ps
`include "scp_consts.svh"
module scp_ctrl_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial control pins
  input wire logic ctrl_select_n,
  input wire logic ctrl_serial_clock,
  input wire logic ctrl_serial_data,
  // mode control fields
  output logic defaults_restore_n,
  output logic system_reset_n,
  output logic [1:0] interface_mode_sel,
  output logic data_format_sel,
  output logic power_down_req,
  output logic polarity_invert,
  output logic mute_req,
  // datapath controls
  output logic output_force_zero,
  output logic fade_out_req,
  output logic digital_clock_stop,
  output logic other_regs_reset,
  output logic mode_write_pulse
);
  import scp_pkg::*;

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic sclk_last_reg;
  logic sclk_last_next;

  // reset released through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // pins gathered as select, clock, data
  assign pin_raw = {ctrl_select_n, ctrl_serial_clock, ctrl_serial_data};

  // two flip-flops per pin before any logic
  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    logic stage1_reg;
    logic stage2_reg;
    // idle high at reset so no false frame opens
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stage1_reg <= 1'b1;
        stage2_reg <= 1'b1;
      end else begin
        stage1_reg <= pin_raw[g];
        stage2_reg <= stage1_reg;
      end
    end
    assign pin_sync[g] = stage2_reg;
  end

  // serial clock level one cycle back
  always_comb begin
    sclk_last_next = pin_sync[1];
  end

  // edge history, reset high so release shows no rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_last_reg <= 1'b1;
    end else begin
      sclk_last_reg <= sclk_last_next;
    end
  end

  logic sel_n_s;
  logic sdat_s;
  logic sclk_rise;
  // synchronised select and data
  assign sel_n_s = pin_sync[2];
  assign sdat_s = pin_sync[0];
  assign sclk_rise = pin_sync[1] & ~sclk_last_reg;

  // ****************************************
  // word receiver
  // ****************************************
  // receiver state, shifter, bit count, mode register, strobe
  scp_state_t state_reg, state_next;
  logic [15:0] shift_reg, shift_next;
  logic [4:0] count_reg, count_next;
  logic [7:0] mode_reg, mode_next;
  logic wr_reg, wr_next;
  logic last_bit;
  logic index_ok;

  assign last_bit = (count_reg == `SCP_WORD_BITS - 5'h01);
  // lead bit zero and index selects the mode register
  assign index_ok = (shift_reg[14] == 1'b0) && (shift_reg[13:7] == `SCP_MODE_CTRL_IDX);

  // next-state logic for receiver and mode register
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    mode_next = mode_reg;
    wr_next = 1'b0;
    unique case (state_reg)
      SCP_IDLE: begin
        if (!sel_n_s) begin
          state_next = SCP_SHIFT;
          count_next = 5'h00;
        end
      end
      SCP_SHIFT: begin
        if (sel_n_s) begin
          state_next = SCP_IDLE;
        end else if (sclk_rise) begin
          shift_next = {shift_reg[14:0], sdat_s};
          count_next = count_reg + 5'h01;
          if (last_bit) begin
            state_next = SCP_WAIT;
            if (index_ok) begin
              // latch after sixteenth clock, low byte
              mode_next = {shift_reg[6:0], sdat_s};
              wr_next = 1'b1;
            end
          end
        end
      end
      SCP_WAIT: begin
        // extra clocks ignored until select high
        if (sel_n_s) begin
          state_next = SCP_IDLE;
        end
      end
    endcase
    // restore bit low reloads defaults
    // a word landing this cycle wins; the reload follows one clock later
    if (!mode_reg[`SCP_BIT_RESTORE] && !wr_next) begin
      mode_next = `SCP_MODE_CTRL_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SCP_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      mode_reg <= `SCP_MODE_CTRL_RESET;
      wr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      mode_reg <= mode_next;
      wr_reg <= wr_next;
    end
  end

  // ****************************************
  // field outputs and datapath controls
  // ****************************************
  // field decode of mode register
  assign defaults_restore_n = mode_reg[`SCP_BIT_RESTORE];
  assign system_reset_n = mode_reg[`SCP_BIT_SYSRST];

  // audio interface mode and format fields
  assign interface_mode_sel = mode_reg[`SCP_BIT_MODE_HI:`SCP_BIT_MODE_LO];
  assign data_format_sel = mode_reg[`SCP_BIT_FORMAT];

  // power-down request and mute fields
  assign power_down_req = mode_reg[`SCP_BIT_PDOWN];
  assign mute_req = mode_reg[`SCP_BIT_MUTE];

  // polarity straight from register, no delay
  assign polarity_invert = mode_reg[`SCP_BIT_POLARITY];

  // system reset forces zero now, no fade
  assign output_force_zero = ~mode_reg[`SCP_BIT_SYSRST];

  assign fade_out_req = mode_reg[`SCP_BIT_PDOWN] | mode_reg[`SCP_BIT_MUTE];
  // clock stop and other registers reset
  assign digital_clock_stop = mode_reg[`SCP_BIT_PDOWN] | ~mode_reg[`SCP_BIT_SYSRST];
  assign other_regs_reset = mode_reg[`SCP_BIT_PDOWN] | ~mode_reg[`SCP_BIT_SYSRST];

  // one-cycle strobe for each accepted word
  assign mode_write_pulse = wr_reg;
endmodule : scp_ctrl_port

// [core/scp_pkg.sv]
// types for the serial mode control port
package scp_pkg;
  typedef enum logic [2:0] {
    SCP_IDLE = 3'b001,
    SCP_SHIFT = 3'b010,
    SCP_WAIT = 3'b100
  } scp_state_t;
endpackage : scp_pkg

// [dv/adc_serial_mode_control_port_tb_top.sv]
// bench for the serial mode control port
`timescale 1ns/10ps
module adc_serial_mode_control_port_tb_top;
  logic clk = 0;
  logic reset_n = 0;
  wire logic ctrl_select_n, ctrl_serial_clock, ctrl_serial_data, mode_write_pulse;
  wire logic [7:0] mb;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  int err_total = 0;
  int compares = 0;
  int seed = 32'h9385;
  scp_host_model u_host (.clk, .ctrl_select_n, .ctrl_serial_clock, .ctrl_serial_data);
  scp_ctrl_port u_dut (.clk, .reset_n, .ctrl_select_n, .ctrl_serial_clock, .ctrl_serial_data,
    .defaults_restore_n(mb[7]), .system_reset_n(mb[6]), .interface_mode_sel(mb[5:4]),
    .data_format_sel(mb[3]), .power_down_req(mb[2]), .polarity_invert(mb[1]), .mute_req(mb[0]),
    .output_force_zero(), .fade_out_req(), .digital_clock_stop(), .other_regs_reset(),
    .mode_write_pulse);
  initial forever #2.5 clk = ~clk;
  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // note only whole words to the mode register
  task wr(input logic [15:0] w, input int n);
    if (n == 16 && w[15:8] == 8'h31) exp_q.push_back(w[7:0]);
    u_host.send(w, n);
  endtask : wr
  // each write pulse against the oldest note, mid-cycle
  always @(negedge clk) begin
    if (mode_write_pulse === 1'b1) check(mb, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  end
  initial begin
    #60000;
    err_total++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(mb, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[7] = 1'b1;
      d[6] = i[2];
      d[5:4] = i[1:0];
      d[2] = i[0];
      wr({8'h31, d}, 16);
    end
    wr(16'h30A5, 16);
    wr(16'hB15A, 16);
    wr(16'h3199, 12);
    wr(16'h317E, 16);
    repeat (3) @(posedge clk);
    check(mb, 8'hC0);
    repeat (20) @(posedge clk);
    check(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule : adc_serial_mode_control_port_tb_top
bind scp_ctrl_port scp_ctrl_port_chk u_chk (.clk, .reset_n, .ctrl_select_n,
  .defaults_restore_n, .system_reset_n, .power_down_req, .output_force_zero,
  .fade_out_req, .digital_clock_stop, .other_regs_reset, .mode_write_pulse);

// [dv/scp_ctrl_port_chk.sv]
// assertions on the serial mode control port
`timescale 1ns/10ps
module scp_ctrl_port_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic ctrl_select_n,
  input wire logic defaults_restore_n,
  input wire logic system_reset_n,
  input wire logic power_down_req,
  input wire logic output_force_zero,
  input wire logic fade_out_req,
  input wire logic digital_clock_stop,
  input wire logic other_regs_reset,
  input wire logic mode_write_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_one; mode_write_pulse |=> !mode_write_pulse; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_frm; mode_write_pulse |-> !$past(ctrl_select_n, 4); endproperty
  a_frm: assert property (p_frm) else $error("write outside frame");
  property p_hold; defaults_restore_n |=>
    mode_write_pulse || $stable({system_reset_n, power_down_req}); endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_rst; mode_write_pulse && !defaults_restore_n |=>
    defaults_restore_n && system_reset_n && !power_down_req; endproperty
  a_rst: assert property (p_rst) else $error("no default reload");
  property p_zero; output_force_zero == !system_reset_n; endproperty
  a_zero: assert property (p_zero) else $error("force zero wrong");
  property p_fade; power_down_req |-> fade_out_req; endproperty
  a_fade: assert property (p_fade) else $error("no fade");
  property p_stop; digital_clock_stop == (power_down_req || !system_reset_n); endproperty
  a_stop: assert property (p_stop) else $error("clock stop wrong");
  property p_oth; other_regs_reset == digital_clock_stop; endproperty
  a_oth: assert property (p_oth) else $error("regs reset wrong");
endmodule : scp_ctrl_port_chk

// [dv/scp_host_model.sv]
// host model driving the serial control pins
`timescale 1ns/10ps
module scp_host_model (
  // bench clock, only to start frames off its falling edge
  input wire logic clk,
  // serial control pins
  output logic ctrl_select_n,
  output logic ctrl_serial_clock,
  output logic ctrl_serial_data
);
  initial begin
    ctrl_select_n = 1'b1;
    ctrl_serial_clock = 1'b0;
    ctrl_serial_data = 1'b1;
  end
  task send(input logic [15:0] w, input int n);
    @(negedge clk);
    ctrl_select_n <= 1'b0;
    #20;
    for (int i = 15; i > 15 - n; i--) begin
      ctrl_serial_data <= w[i];
      #24 ctrl_serial_clock <= 1'b1;
      #24 ctrl_serial_clock <= 1'b0;
    end
    #10 ctrl_select_n <= 1'b1;
    ctrl_serial_data <= ~ctrl_serial_data;
    #30;
  endtask : send
endmodule : scp_host_model
